// >>> hw/fbls_top.sv
// Purpose: block lock states, handshake pin sequencing and first address
//          latching of a configuration flash, with APB registers
// Assumes: pins pass two flip-flops; host clock pin sampled as a level
// Notes:   program and erase are modelled by completion timers only
//
// Behaviour
// - lock, unlock and lock-down are accepted while an erase is suspended
// - locking the block under suspended erase is immediate; erase completes
// - protection commands are refused while a program is suspended
// - state is pin, locked-down, locked; program/erase need locked clear
// - lock sets locked; unlock clears unless 0,1,1; lock-down sets both
// - pin low forces locked-down blocks locked; pin high restores locked
// - after power-up all blocks are locked with locked-down clear
// - ready/wait pin held low during power-on reset and reset pulse
// - ready/wait released only after the release delay past thresholds
// - core supply under power-down threshold resets and holds pin low
// - start address captured on third clock edge after ready/wait high
// - latching restarts when ready/wait is low with select bit 1
// - after power-on start on later of both edges, else ready/wait rise
// - software cannot clear locked-down; only hardware reset does
// - program or erase on a locked block is refused and flagged
`timescale 1ns/1ps
`default_nettype none
module fbls_top #(
	parameter int PROG_CYCLES  = fbls_pkg::PROG_CYC,
	parameter int ERASE_CYCLES = fbls_pkg::ERASE_CYC
) (
	input  wire logic                        pclk,
	input  wire logic                        presetn,
	input  wire logic                        ce,
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [7:0]                  paddr,
	input  wire logic [31:0]                 pwdata,
	output var  logic [31:0]                 prdata,
	output logic                             pready,
	output var  logic                        pslverr,
	input  wire logic                        reset_pin_n,
	input  wire logic                        write_protect_n,
	input  wire logic                        supplies_above_por,
	input  wire logic                        core_below_pd,
	input  wire logic                        latch_enable_n,
	input  wire logic                        output_enable_n,
	input  wire logic                        host_clk,
	input  wire logic [fbls_pkg::ADDR_W-1:0] addr_pin,
	input  wire logic                        ready_wait_i,
	output logic                             ready_wait_o,
	output var  logic                        ready_wait_oe,
	output var  logic [fbls_pkg::ADDR_W-1:0] burst_addr
);
	import fbls_pkg::*;

	// ------------------------------------------------------------------
	// pin synchronisation
	// ------------------------------------------------------------------
	fbls_sync_if #(.W(PIN_W)) pins (.clk(pclk), .rst_n(presetn), .ce(ce));
	fbls_sync #(.W(PIN_W)) u_sync (.s(pins));

	assign pins.raw = {reset_pin_n, write_protect_n, supplies_above_por,
		core_below_pd, latch_enable_n, output_enable_n, host_clk,
		ready_wait_i, addr_pin};

	logic              rp_s, wp_s, por_s, pd_s, le_s, oe_s, k_s, rw_s;
	logic [ADDR_W-1:0] addr_s;
	assign {rp_s, wp_s, por_s, pd_s, le_s, oe_s, k_s, rw_s, addr_s} =
		pins.sync;

	logic wp_q, k_q, rw_q;
	logic hw_reset, power_loss;
	// brownout and missing supplies count as a power-on reset
	assign power_loss = pd_s | ~por_s;
	assign hw_reset   = power_loss | ~rp_s;

	// edge detectors look at the second stage only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wp_q <= 1'b0;
			k_q  <= 1'b0;
			rw_q <= 1'b0;
		end else if (ce) begin
			wp_q <= wp_s;
			k_q  <= k_s;
			rw_q <= rw_s;
		end
	end

	logic wp_fall, wp_rise, k_rise, rw_rise;
	assign wp_fall = wp_q & ~wp_s;
	assign wp_rise = ~wp_q & wp_s;
	assign k_rise  = ~k_q & k_s;
	assign rw_rise = ~rw_q & rw_s;

	// ------------------------------------------------------------------
	// APB decode
	// ------------------------------------------------------------------
	logic            wr, cmd_go, st_clr;
	logic            sel_bit;
	logic [BLK_W-1:0] cmd_blk, rd_blk;
	fbls_cmd_t       cmd_op;
	// zero wait states; a low enable stretches the access
	assign pready  = ce;
	assign wr      = psel & penable & pwrite & ce;
	assign cmd_go  = wr & (paddr == OFS_CMD);
	assign st_clr  = wr & (paddr == OFS_STATUS);
	assign cmd_op  = fbls_cmd_t'(pwdata[CMD_OP_LSB +: 4]);
	assign cmd_blk = pwdata[CMD_BLK_LSB +: BLK_W];

	// control and block select registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sel_bit <= CTRL_SEL_RST;
			rd_blk  <= '0;
		end else if (ce) begin
			if (wr && paddr == OFS_CTRL) begin
				sel_bit <= pwdata[CTRL_SEL_BIT];
			end
			if (wr && paddr == OFS_BLKSEL) begin
				rd_blk <= pwdata[BLK_W-1:0];
			end
		end
	end

	// ------------------------------------------------------------------
	// program and erase sequencing
	// ------------------------------------------------------------------
	fbls_op_t         prog_st, erase_st;
	logic [31:0]      prog_cnt, erase_cnt;
	logic [BLK_W-1:0] erase_blk;
	logic [NUM_BLOCKS-1:0] locked, lockdown, saved_locked;
	logic             lock_err_set, reject_set, lock_cmd, lock_ok;
	logic             pe_target_locked;

	assign pe_target_locked = locked[cmd_blk];
	assign lock_cmd = cmd_go & (cmd_op == CMD_LOCK || cmd_op == CMD_UNLOCK
		|| cmd_op == CMD_LOCKDOWN);
	assign lock_ok  = lock_cmd & (prog_st != OP_SUSP);

	// lock state is checked at start only, so a lock during a suspended
	// erase of the same block does not abort it once resumed
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			erase_st  <= OP_IDLE;
			erase_cnt <= '0;
			erase_blk <= '0;
		end else if (ce) begin
			if (hw_reset) begin
				erase_st <= OP_IDLE;
			end else begin
				case (erase_st)
					OP_IDLE: begin
						if (cmd_go && cmd_op == CMD_ERASE && prog_st == OP_IDLE
							&& !pe_target_locked) begin
							erase_st  <= OP_RUN;
							erase_cnt <= ERASE_CYCLES;
							erase_blk <= cmd_blk;
						end
					end
					OP_RUN: begin
						if (cmd_go && cmd_op == CMD_ERASE_SUSP) begin
							erase_st <= OP_SUSP;
						end else if (erase_cnt <= 32'h0000_0001) begin
							erase_st <= OP_IDLE;
						end else begin
							erase_cnt <= erase_cnt - 32'h0000_0001;
						end
					end
					OP_SUSP: begin
						if (cmd_go && cmd_op == CMD_ERASE_RES
							&& prog_st == OP_IDLE) begin
							erase_st <= OP_RUN;
						end
					end
					default: erase_st <= OP_IDLE;
				endcase
			end
		end
	end

	// a program may run beside a suspended erase, not beside a running one
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prog_st  <= OP_IDLE;
			prog_cnt <= '0;
		end else if (ce) begin
			if (hw_reset) begin
				prog_st <= OP_IDLE;
			end else begin
				case (prog_st)
					OP_IDLE: begin
						if (cmd_go && cmd_op == CMD_PROGRAM
							&& erase_st != OP_RUN
							&& !pe_target_locked) begin
							prog_st  <= OP_RUN;
							prog_cnt <= PROG_CYCLES;
						end
					end
					OP_RUN: begin
						if (cmd_go && cmd_op == CMD_PROG_SUSP) begin
							prog_st <= OP_SUSP;
						end else if (prog_cnt <= 32'h0000_0001) begin
							prog_st <= OP_IDLE;
						end else begin
							prog_cnt <= prog_cnt - 32'h0000_0001;
						end
					end
					OP_SUSP: begin
						if (cmd_go && cmd_op == CMD_PROG_RES) begin
							prog_st <= OP_RUN;
						end
					end
					default: prog_st <= OP_IDLE;
				endcase
			end
		end
	end

	// ------------------------------------------------------------------
	// sticky error flags; a new event beats a clear in the same cycle
	// ------------------------------------------------------------------
	logic lock_err, reject;
	assign lock_err_set = cmd_go & pe_target_locked
		& (cmd_op == CMD_PROGRAM || cmd_op == CMD_ERASE);
	assign reject_set = lock_cmd & ~lock_ok;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lock_err <= 1'b0;
			reject   <= 1'b0;
		end else if (ce) begin
			lock_err <= lock_err_set
				| (lock_err & ~(st_clr & pwdata[ST_LOCKERR_BIT]));
			reject   <= reject_set
				| (reject & ~(st_clr & pwdata[ST_REJECT_BIT]));
		end
	end

	// ------------------------------------------------------------------
	// per-block protection state
	// ------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			locked       <= '1;
			lockdown     <= '0;
			saved_locked <= '1;
		end else if (ce) begin
			if (hw_reset) begin
				locked       <= '1;
				lockdown     <= '0;
				saved_locked <= '1;
			end else begin
				for (int i = 0; i < NUM_BLOCKS; i++) begin
					if (wp_fall && lockdown[i]) begin
						saved_locked[i] <= locked[i];
						locked[i]       <= 1'b1;
					end else if (wp_rise && lockdown[i]) begin
						locked[i] <= saved_locked[i];
					end else if (lock_ok && cmd_blk == BLK_W'(i)) begin
						case (cmd_op)
							CMD_LOCK: locked[i] <= 1'b1;
							CMD_UNLOCK: begin
								// software never clears locked-down
								if (wp_s || !lockdown[i]) begin
									locked[i] <= 1'b0;
								end
							end
							CMD_LOCKDOWN: begin
								locked[i]       <= 1'b1;
								lockdown[i]     <= 1'b1;
								saved_locked[i] <= 1'b1;
							end
							default: locked[i] <= locked[i];
						endcase
					end
				end
			end
		end
	end

	// ------------------------------------------------------------------
	// handshake pin: low in reset, released after the delay
	// ------------------------------------------------------------------
	logic [15:0] rel_cnt;
	logic        released;
	assign ready_wait_o = 1'b0;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rel_cnt       <= '0;
			released      <= 1'b0;
			ready_wait_oe <= 1'b1;
		end else if (ce) begin
			if (hw_reset) begin
				rel_cnt       <= '0;
				released      <= 1'b0;
				ready_wait_oe <= 1'b1;
			end else if (rel_cnt < 16'(RELEASE_CYC - 1)) begin
				rel_cnt <= rel_cnt + 16'h0001;
			end else begin
				released      <= 1'b1;
				ready_wait_oe <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------------
	// first address latching and burst addressing
	// ------------------------------------------------------------------
	fbls_first_address_latch_sequence_t        first_address_latch_sequence_st;
	logic [2:0]        edge_cnt;
	logic              por_boot, first_address_latch_sequence_start;
	logic [ADDR_W-1:0] start_addr;

	// after power-on both levels must hold; later only a pin rise starts
	assign first_address_latch_sequence_start = ~le_s ? 1'b0 : ~oe_s & rp_s
		& (por_boot ? rw_s : rw_rise);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			first_address_latch_sequence_st    <= FIRST_ADDRESS_LATCH_SEQUENCE_IDLE;
			edge_cnt   <= '0;
			por_boot   <= 1'b1;
			start_addr <= '0;
			burst_addr <= '0;
		end else if (ce) begin
			if (power_loss) begin
				por_boot <= 1'b1;
			end else if (!rp_s || (first_address_latch_sequence_st == FIRST_ADDRESS_LATCH_SEQUENCE_IDLE && first_address_latch_sequence_start)) begin
				por_boot <= 1'b0;
			end
			if (hw_reset || (sel_bit && !rw_s)) begin
				first_address_latch_sequence_st  <= FIRST_ADDRESS_LATCH_SEQUENCE_IDLE;
				edge_cnt <= '0;
			end else begin
				case (first_address_latch_sequence_st)
					FIRST_ADDRESS_LATCH_SEQUENCE_IDLE: begin
						if (first_address_latch_sequence_start) begin
							first_address_latch_sequence_st  <= FIRST_ADDRESS_LATCH_SEQUENCE_EDGES;
							edge_cnt <= '0;
						end
					end
					FIRST_ADDRESS_LATCH_SEQUENCE_EDGES: begin
						if (k_rise) begin
							edge_cnt <= edge_cnt + 3'd1;
							if (edge_cnt == 3'(FIRST_ADDRESS_LATCH_SEQUENCE_LATCH_EDGE - 1)) begin
								start_addr <= addr_s;
								burst_addr <= addr_s;
							end
							if (edge_cnt == 3'(FIRST_ADDRESS_LATCH_SEQUENCE_LAST_EDGE - 1)) begin
								first_address_latch_sequence_st <= FIRST_ADDRESS_LATCH_SEQUENCE_BURST;
							end
						end
					end
					FIRST_ADDRESS_LATCH_SEQUENCE_BURST: begin
						if (k_rise) begin
							burst_addr <= burst_addr + 1'b1;
						end
					end
					default: first_address_latch_sequence_st <= FIRST_ADDRESS_LATCH_SEQUENCE_IDLE;
				endcase
			end
		end
	end

	// ------------------------------------------------------------------
	// APB read data, captured in the setup cycle
	// ------------------------------------------------------------------
	logic [31:0] rd_mux;
	logic        rd_bad;
	always_comb begin
		rd_mux = 32'h0000_0000;
		rd_bad = 1'b0;
		case (paddr)
			OFS_CTRL:   rd_mux[CTRL_SEL_BIT] = sel_bit;
			OFS_CMD:    rd_mux = 32'h0000_0000;
			OFS_STATUS: begin
				rd_mux[ST_READY_BIT]   = released;
				rd_mux[ST_LOCKERR_BIT] = lock_err;
				rd_mux[ST_REJECT_BIT]  = reject;
				rd_mux[ST_FIRST_ADDRESS_LATCH_SEQUENCE_BIT]    = (first_address_latch_sequence_st == FIRST_ADDRESS_LATCH_SEQUENCE_BURST);
				rd_mux[ST_WP_BIT]      = wp_s;
				rd_mux[ST_ERUN_BIT]    = (erase_st == OP_RUN);
				rd_mux[ST_ESUSP_BIT]   = (erase_st == OP_SUSP);
				rd_mux[ST_PRUN_BIT]    = (prog_st == OP_RUN);
				rd_mux[ST_PSUSP_BIT]   = (prog_st == OP_SUSP);
			end
			OFS_BLKSEL: rd_mux[BLK_W-1:0] = rd_blk;
			OFS_LOCK:   rd_mux[2:0] = {wp_s, lockdown[rd_blk],
				locked[rd_blk]};
			OFS_START:  rd_mux[ADDR_W-1:0] = start_addr;
			OFS_BURST:  rd_mux[ADDR_W-1:0] = burst_addr;
			default:    rd_bad = 1'b1;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= '0;
			pslverr <= 1'b0;
		end else if (ce && psel && !penable) begin
			prdata  <= pwrite ? 32'h0000_0000 : rd_mux;
			pslverr <= rd_bad;
		end
	end

	// unused erase block index kept for status growth
	logic unused_ok;
	assign unused_ok = ^erase_blk;
endmodule
`default_nettype wire

// >>> hw/fbls_pkg.sv
// Purpose: shared constants and types of the flash block lock and start-up
// Assumes: 32-bit APB register words, 250 MHz pclk
// Notes:   register map, field layout, reset values and timing counts
package fbls_pkg;
	// ------------------------------------------------------------------
	// sizes
	// ------------------------------------------------------------------
	localparam int NUM_BLOCKS = 16;
	localparam int BLK_W      = 4;
	localparam int ADDR_W     = 16;
	localparam int PIN_W      = 8 + ADDR_W;

	// ------------------------------------------------------------------
	// register offsets (byte addresses)
	// ------------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_CMD    = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	localparam logic [7:0] OFS_BLKSEL = 8'h0C;
	localparam logic [7:0] OFS_LOCK   = 8'h10;
	localparam logic [7:0] OFS_START  = 8'h14;
	localparam logic [7:0] OFS_BURST  = 8'h18;

	// ------------------------------------------------------------------
	// field positions and reset values
	// ------------------------------------------------------------------
	localparam int CTRL_SEL_BIT   = 0;
	localparam logic CTRL_SEL_RST = 1'b1;
	localparam int CMD_OP_LSB     = 0;
	localparam int CMD_BLK_LSB    = 8;
	localparam int ST_READY_BIT   = 0;
	localparam int ST_LOCKERR_BIT = 1;
	localparam int ST_REJECT_BIT  = 2;
	localparam int ST_FIRST_ADDRESS_LATCH_SEQUENCE_BIT    = 3;
	localparam int ST_WP_BIT      = 4;
	localparam int ST_ERUN_BIT    = 5;
	localparam int ST_ESUSP_BIT   = 6;
	localparam int ST_PRUN_BIT    = 7;
	localparam int ST_PSUSP_BIT   = 8;

	// ------------------------------------------------------------------
	// timing
	// ------------------------------------------------------------------
	localparam int CLK_MHZ      = 250;
	localparam int T_RELEASE_NS = 1000;
	localparam int RELEASE_CYC  = (T_RELEASE_NS * CLK_MHZ + 999) / 1000;
	localparam int T_PROG_US    = 180;
	localparam int PROG_CYC     = T_PROG_US * CLK_MHZ;
	localparam int T_ERASE_MS   = 2500;
	localparam int ERASE_CYC    = T_ERASE_MS * 1000 * CLK_MHZ;
	localparam int FIRST_ADDRESS_LATCH_SEQUENCE_LATCH_EDGE = 3;
	localparam int FIRST_ADDRESS_LATCH_SEQUENCE_LAST_EDGE  = 4;

	// ------------------------------------------------------------------
	// types
	// ------------------------------------------------------------------
	typedef enum logic [3:0] {
		CMD_NONE       = 4'h0,
		CMD_LOCK       = 4'h1,
		CMD_UNLOCK     = 4'h2,
		CMD_LOCKDOWN   = 4'h3,
		CMD_PROGRAM    = 4'h4,
		CMD_ERASE      = 4'h5,
		CMD_PROG_SUSP  = 4'h6,
		CMD_PROG_RES   = 4'h7,
		CMD_ERASE_SUSP = 4'h8,
		CMD_ERASE_RES  = 4'h9
	} fbls_cmd_t;

	typedef enum logic [1:0] {
		OP_IDLE = 2'b00,
		OP_RUN  = 2'b01,
		OP_SUSP = 2'b10
	} fbls_op_t;

	typedef enum logic [1:0] {
		FIRST_ADDRESS_LATCH_SEQUENCE_IDLE  = 2'b00,
		FIRST_ADDRESS_LATCH_SEQUENCE_EDGES = 2'b01,
		FIRST_ADDRESS_LATCH_SEQUENCE_BURST = 2'b10
	} fbls_first_address_latch_sequence_t;
endpackage

// >>> hw/fbls_sync_if.sv
// Purpose: carries raw pin levels to the synchroniser and back
// Assumes: one pclk domain
// Notes:   clock, reset and enable travel with the data
`timescale 1ns/1ps
`default_nettype none
interface fbls_sync_if #(parameter int W = 1) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce
);
	logic [W-1:0] raw;
	logic [W-1:0] sync;
	modport user (output raw, input sync, input clk, input rst_n, input ce);
	modport sync_side (input raw, output sync, input clk, input rst_n,
		input ce);
endinterface
`default_nettype wire

// >>> hw/fbls_sync.sv
// Purpose: two flip-flop synchroniser for a group of pin inputs
// Assumes: inputs change slowly against pclk
// Notes:   multi-bit groups are only sampled as separate levels
`timescale 1ns/1ps
`default_nettype none
module fbls_sync #(
	parameter int W = 1
) (
	fbls_sync_if.sync_side s
);
	logic [W-1:0] meta;

	// ------------------------------------------------------------------
	// two stages; only the second stage is read by anybody
	// ------------------------------------------------------------------
	always_ff @(posedge s.clk or negedge s.rst_n) begin
		if (!s.rst_n) begin
			meta   <= '0;
			s.sync <= '0;
		end else if (s.ce) begin
			meta   <= s.raw;
			s.sync <= meta;
		end
	end
endmodule
`default_nettype wire

// >>> tb/fbls_monitor.sv
// Purpose: port checks of ready/wait sequencing and address latching
// Assumes: ce high wherever a window of cycles is judged
// Notes:   bound into fbls_top after the module
`timescale 1ns/1ps
`default_nettype none
module fbls_monitor (
	input wire logic			pclk,
	input wire logic			presetn,
	input wire logic			ce,
	input wire logic			psel,
	input wire logic			penable,
	input wire logic [7:0]			paddr,
	input wire logic			pslverr,
	input wire logic			reset_pin_n,
	input wire logic			supplies_above_por,
	input wire logic			core_below_pd,
	input wire logic			ready_wait_i,
	input wire logic			ready_wait_oe,
	input wire logic [fbls_pkg::ADDR_W-1:0]	burst_addr
);
	import fbls_pkg::*;
	logic [8:0]	ok_cnt;
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// healthy supply cycles; saturates so a long run never wraps
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			ok_cnt <= 9'h000;
		else if (!supplies_above_por || core_below_pd || !reset_pin_n)
			ok_cnt <= 9'h000;
		else if (ce && ok_cnt != 9'h1FF)
			ok_cnt <= ok_cnt + 9'h001;
	end
	a_pin_rst_low: assert property (
		(!reset_pin_n && ce)[*4] |-> ready_wait_oe)
		else $error("ready wait free during reset pulse");
	a_brownout_low: assert property (
		(core_below_pd && ce)[*4] |-> ready_wait_oe)
		else $error("ready wait free during brownout");
	a_por_hold: assert property (
		(!supplies_above_por && ce)[*4] |-> ready_wait_oe)
		else $error("ready wait free below supply threshold");
	a_release_delay: assert property (
		$fell(ready_wait_oe) |-> ok_cnt >= RELEASE_CYC)
		else $error("ready wait released too early");
	a_abandon_hold: assert property (
		(!ready_wait_i && ce)[*5] |=>
		($stable(burst_addr) || burst_addr == '0))
		else $error("burst address moved while wire low");
	a_latch_after_rw: assert property (
		$changed(burst_addr) && burst_addr != '0 |-> $past(ready_wait_i, 4))
		else $error("address latched without ready wait high");
	a_unmapped_err: assert property (
		psel && !penable && ce && paddr > OFS_BURST |=> pslverr)
		else $error("unmapped access without error");
	a_mapped_ok: assert property (
		psel && !penable && paddr <= OFS_BURST && paddr[1:0] == 2'b00
		|=> !pslverr)
		else $error("mapped access flagged as error");
endmodule
bind fbls_top fbls_monitor mon_i (
	.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
	.penable(penable), .paddr(paddr), .pslverr(pslverr),
	.reset_pin_n(reset_pin_n), .supplies_above_por(supplies_above_por),
	.core_below_pd(core_below_pd), .ready_wait_i(ready_wait_i),
	.ready_wait_oe(ready_wait_oe), .burst_addr(burst_addr)
);
`default_nettype wire

// >>> tb/fbls_host.sv
// Purpose: configuration controller facing the start-up pins
// Assumes: gated host clock, 4 pclk per clock phase
// Notes:   clock stands low outside frames
`timescale 1ns/1ps
`default_nettype none
module fbls_host (
	input wire logic			pclk,
	input wire logic			rw_wire,
	output var logic			latch_enable_n,
	output var logic			output_enable_n,
	output var logic			host_clk,
	output var logic [fbls_pkg::ADDR_W-1:0]	addr_pin
);
	import fbls_pkg::*;
	localparam int GAP_CYC = 150; // 600 ns at 250 MHz
	// enables held for the whole run so any wire rise may start a frame
	initial begin
		latch_enable_n = 1'b1;
		output_enable_n = 1'b0;
		host_clk = 1'b0;
		addr_pin = '0;
	end
	// one frame of n rises with the start address held throughout
	task automatic frame(input logic [ADDR_W-1:0] a, input int n);
		int i;
		for (i = 0; i < 2000 && rw_wire !== 1'b1; i++)
			@(posedge pclk);
		repeat (GAP_CYC) @(posedge pclk);
		addr_pin <= a;
		repeat (n) begin
			repeat (4) @(posedge pclk);
			host_clk <= 1'b1;
			repeat (4) @(posedge pclk);
			host_clk <= 1'b0;
		end
		repeat (4) @(posedge pclk);
		addr_pin <= ~a; // released lines show the inverse
	endtask
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
// Purpose: self-checking bench of the lock and start-up block
// Assumes: ce held high except for one cycle in t_power; program and erase timers shortened
// Notes:   the ready/wait wire has a pull-up
`timescale 1ns/1ps
`default_nettype none
`define CK(a, b) begin \
	samples_checked++; \
	if ((a) !== (b)) begin \
		n_fail++; \
		$display("Error t=%0t got %0h exp %0h", $time, (a), (b)); \
	end \
end
module tb_top;
	import fbls_pkg::*;
	logic		pclk = 1'b0;
	logic		presetn = 1'b0;
	logic		ce = 1'b1;
	logic		psel = 1'b0;
	logic		penable = 1'b0;
	logic		pwrite = 1'b0;
	logic [7:0]	paddr = 8'h00;
	logic [31:0]	pwdata = 32'h0;
	logic [31:0]	prdata, rd;
	logic		pready, pslverr, err;
	logic		rst_pin_n = 1'b1;
	logic		wp_n = 1'b1;
	logic		por_ok = 1'b0;
	logic		below_pd = 1'b0;
	logic		host_pull = 1'b0;
	logic		le_n, oe_n, hclk, rw_i, rw_o, rw_oe;
	logic [15:0]	addr_pin, burst_addr;
	int		n_fail = 0;
	int		samples_checked = 0;
	int		cycles = 0;
	// wire low when the device or the host pulls it
	assign rw_i = rw_oe ? (rw_o & !host_pull) : !host_pull;
	always #2 pclk = ~pclk;
	fbls_top #(.PROG_CYCLES(20), .ERASE_CYCLES(40)) DUT (
		.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .reset_pin_n(rst_pin_n),
		.write_protect_n(wp_n), .supplies_above_por(por_ok),
		.core_below_pd(below_pd), .latch_enable_n(le_n),
		.output_enable_n(oe_n), .host_clk(hclk), .addr_pin(addr_pin),
		.ready_wait_i(rw_i), .ready_wait_o(rw_o),
		.ready_wait_oe(rw_oe), .burst_addr(burst_addr));
	fbls_host host_m (.pclk(pclk), .rw_wire(rw_i),
		.latch_enable_n(le_n), .output_enable_n(oe_n),
		.host_clk(hclk), .addr_pin(addr_pin));
	task automatic conclude();
		if (n_fail == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// one transfer; request held until pready is seen at an edge
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic cmd(input logic [3:0] op, input logic [3:0] blk);
		apb(1'b1, OFS_CMD, {20'h0, blk, 4'h0, op});
	endtask
	task automatic exp_lock(input logic [3:0] blk, input logic [2:0] e);
		apb(1'b1, OFS_BLKSEL, {28'h0, blk});
		apb(1'b0, OFS_LOCK, 32'h0);
		`CK(rd[2:0], e)
	endtask
	// status poll; bounded so a stuck bit cannot hang the run
	task automatic wait_st(input int b, input logic v);
		int i;
		for (i = 0; i < 100; i++) begin
			apb(1'b0, OFS_STATUS, 32'h0);
			if (rd[b] === v)
				break;
		end
		`CK(rd[b], v)
	endtask
	task automatic wait_rw();
		int i;
		for (i = 0; i < 600 && rw_i !== 1'b1; i++)
			@(posedge pclk);
		`CK(rw_i, 1'b1)
	endtask
	task automatic t_power();
		wait_rw();
		wait_st(ST_READY_BIT, 1'b1);
		exp_lock(4'h0, 3'b101);
		exp_lock(4'hF, 3'b101);
		apb(1'b0, 8'h40, 32'h0);
		`CK(err, 1'b1)
		// a low enable must stall the bus answer
		ce <= 1'b0;
		@(posedge pclk);
		`CK(pready, 1'b0)
		ce <= 1'b1;
	endtask
	task automatic t_lock();
		cmd(CMD_UNLOCK, 4'h3);
		exp_lock(4'h3, 3'b100);
		cmd(CMD_LOCKDOWN, 4'h3);
		exp_lock(4'h3, 3'b111);
		cmd(CMD_UNLOCK, 4'h3);
		exp_lock(4'h3, 3'b110);
		wp_n <= 1'b0;
		exp_lock(4'h3, 3'b011);
		wait_st(ST_WP_BIT, 1'b0);
		cmd(CMD_UNLOCK, 4'h3);
		exp_lock(4'h3, 3'b011);
		wp_n <= 1'b1;
		exp_lock(4'h3, 3'b110);
	endtask
	task automatic t_prog();
		cmd(CMD_PROGRAM, 4'h5);
		wait_st(ST_LOCKERR_BIT, 1'b1);
		wait_st(ST_PRUN_BIT, 1'b0);
		apb(1'b1, OFS_STATUS, 32'h2);
		cmd(CMD_UNLOCK, 4'h7);
		cmd(CMD_PROGRAM, 4'h7);
		cmd(CMD_PROG_SUSP, 4'h7);
		wait_st(ST_PSUSP_BIT, 1'b1);
		cmd(CMD_LOCK, 4'h7);
		wait_st(ST_REJECT_BIT, 1'b1);
		exp_lock(4'h7, 3'b100);
		cmd(CMD_PROG_RES, 4'h7);
		wait_st(ST_PRUN_BIT, 1'b0);
		wait_st(ST_LOCKERR_BIT, 1'b0);
	endtask
	task automatic t_erase();
		cmd(CMD_ERASE, 4'h3);
		cmd(CMD_ERASE_SUSP, 4'h3);
		wait_st(ST_ESUSP_BIT, 1'b1);
		cmd(CMD_LOCKDOWN, 4'h3);
		exp_lock(4'h3, 3'b111);
		cmd(CMD_ERASE_RES, 4'h3);
		wait_st(ST_ERUN_BIT, 1'b1);
		wait_st(ST_ERUN_BIT, 1'b0);
		wait_st(ST_LOCKERR_BIT, 1'b0);
	endtask
	task automatic t_first_address_latch_sequence();
		host_m.frame(16'h1234, 6);
		apb(1'b0, OFS_START, 32'h0);
		`CK(rd[15:0], 16'h1234)
		`CK(burst_addr, 16'h1236)
		apb(1'b0, OFS_BURST, 32'h0);
		`CK(rd[15:0], 16'h1236)
		// with the select bit clear a low wire must not abandon the burst
		apb(1'b1, OFS_CTRL, 32'h0);
		host_pull <= 1'b1;
		repeat (10) @(posedge pclk);
		host_pull <= 1'b0;
		wait_st(ST_FIRST_ADDRESS_LATCH_SEQUENCE_BIT, 1'b1);
		apb(1'b1, OFS_CTRL, 32'h1);
		apb(1'b0, OFS_CTRL, 32'h0);
		`CK(rd[0], 1'b1)
	endtask
	// reset pulse, then a frame cut short by the host pulling the wire
	task automatic t_reset();
		rst_pin_n <= 1'b0;
		repeat (10) @(posedge pclk);
		`CK(rw_i, 1'b0)
		`CK(rw_o, 1'b0)
		rst_pin_n <= 1'b1;
		wait_rw();
		exp_lock(4'h3, 3'b101);
		host_m.frame(16'h0ABC, 2);
		host_pull <= 1'b1;
		repeat (10) @(posedge pclk);
		host_pull <= 1'b0;
		host_m.frame(16'h5555, 3);
		`CK(burst_addr, 16'h5555)
	endtask
	task automatic t_brown();
		below_pd <= 1'b1;
		repeat (10) @(posedge pclk);
		`CK(rw_i, 1'b0)
		below_pd <= 1'b0;
		wait_rw();
		host_m.frame(16'h0F0F, 4);
		`CK(burst_addr, 16'h0F0F)
	endtask
	// hang guard: the whole sequence needs well under this
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 20000) begin
			n_fail++;
			conclude();
		end
	end
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		repeat (8) @(posedge pclk);
		por_ok <= 1'b1;
		t_power();
		t_lock();
		t_prog();
		t_erase();
		t_first_address_latch_sequence();
		t_reset();
		t_brown();
		conclude();
	end
endmodule
`default_nettype wire
